// File: rtl/pmcs_map.vh
// Constants for the power mode and clock select block.
// Assumes inclusion by bare name from the design file.
`ifndef PMCS_MAP_VH
`define PMCS_MAP_VH
// Oscillator control register field positions
`define PMCS_IDLE_BIT 7
`define PMCS_SRC_HI 1
`define PMCS_SRC_LO 0
`define PMCS_OSC_RST 8'h00
// Source select encodings
`define PMCS_SRC_PRI 2'h0
`define PMCS_SRC_SEC 2'h1
// Mode state codes
`define PMCS_ST_RUN 2'h0
`define PMCS_ST_IDLE 2'h1
`define PMCS_ST_SLEEP 2'h2
// Operating mode codes reported on mode_o
`define PMCS_MODE_SLEEP 3'h0
`define PMCS_MODE_PRIMARY_RUN_MODE 3'h1
`define PMCS_MODE_SECONDARY_RUN_MODE 3'h2
`define PMCS_MODE_INT_RUN 3'h3
`define PMCS_MODE_PRIMARY_IDLE_MODE 3'h4
`define PMCS_MODE_SECONDARY_IDLE_MODE 3'h5
`define PMCS_MODE_INT_IDLE 3'h6
// Clock transition delay in cycles
`define PMCS_SWITCH_DLY 4'h4
`endif

// File: rtl/pmcs_power_mode_clock_select.v
// Power mode controller: chooses clock source and gates CPU and peripheral clocks.
// Assumes the core writes the control register and pulses halt, all on core_clk_i.
// Assumes running flags, configuration and postscale select are steady levels.
`timescale 1ns/10ps
`include "pmcs_map.vh"
module pmcs_power_mode_clock_select #(
    parameter DLY_W = 4
) (
    input wire core_clk_i,
    input wire reset_i,
    // Core side: register writes, halt and wake
    input wire osc_wr_i,
    input wire [7:0] osc_wdata_i,
    input wire halt_i,
    input wire wake_i,
    // Oscillator side: fixed configuration and running flags
    input wire [3:0] primary_osc_config_i,
    input wire [2:0] src_running_i,
    input wire int_postscale_sel_i,
    // Register readback and its two fields
    output wire [7:0] oscillator_control_reg_o,
    output wire cpu_idle_select_o,
    output wire [1:0] clock_source_select_o,
    // Source and gate controls toward the clock tree
    output reg [2:0] src_active_o,
    output reg int_fast_en_o,
    output reg int_slow_en_o,
    output reg [3:0] primary_osc_config_o,
    output reg cpu_clk_en_o,
    output reg periph_clk_en_o,
    output reg [2:0] mode_o,
    output wire switch_busy_o
);
    reg [7:0] osc_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] cur_src_r;
    reg [1:0] pend_src_r;
    reg [DLY_W-1:0] dly_r;
    reg busy_r;
    wire [1:0] req_src;
    wire [2:0] req_onehot;
    wire [2:0] cur_onehot;
    // Output stage helpers: mode offset and internal block enable
    wire [2:0] src_ofs;
    wire int_src_on;

    // State codes kept local so the case arms read as modes, not numbers
    localparam [1:0] ST_RUN = `PMCS_ST_RUN;
    localparam [1:0] ST_IDLE = `PMCS_ST_IDLE;
    localparam [1:0] ST_SLEEP = `PMCS_ST_SLEEP;

    // First code of the run group and of the idle group of modes
    localparam [2:0] MODE_RUN_BASE = `PMCS_MODE_PRIMARY_RUN_MODE;
    localparam [2:0] MODE_IDLE_BASE = `PMCS_MODE_PRIMARY_IDLE_MODE;
    // Counter load: busy spans the load cycle plus the count down to zero
    localparam [DLY_W-1:0] DLY_LOAD = `PMCS_SWITCH_DLY - 4'h1;

    // Readback and field views come straight from the register
    assign oscillator_control_reg_o = osc_r;
    assign cpu_idle_select_o = osc_r[`PMCS_IDLE_BIT];
    assign clock_source_select_o = osc_r[`PMCS_SRC_HI:`PMCS_SRC_LO];
    assign switch_busy_o = busy_r;

    // One-hot source select: bit0 primary, bit1 secondary, bit2 internal
    // Codes 10 and 11 both pick the internal block
    function [2:0] src_onehot;
        input [1:0] s;
        begin
            if (s == `PMCS_SRC_PRI) begin
                src_onehot = 3'h1;
            end else if (s == `PMCS_SRC_SEC) begin
                src_onehot = 3'h2;
            end else begin
                src_onehot = 3'h4;
            end
        end
    endfunction

    // Requested and current source, both one-hot
    assign req_src = osc_r[`PMCS_SRC_HI:`PMCS_SRC_LO];
    assign req_onehot = src_onehot(req_src);
    assign cur_onehot = src_onehot(cur_src_r);
    // Position of the current source inside a group of three modes
    assign src_ofs = {1'b0, cur_onehot[2], cur_onehot[1]};
    // Internal block enabled only while it drives and the part is not asleep
    assign int_src_on = (state_nxt != ST_SLEEP) && cur_onehot[2];

    // Control register; only bits 7 and 1:0 are implemented, others read zero
    // Dropping bits 6:2 keeps software from parking state this block ignores
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            osc_r <= `PMCS_OSC_RST;
        end else if (osc_wr_i) begin
            osc_r <= {osc_wdata_i[7], 5'h00, osc_wdata_i[1:0]};
        end
    end

    // Source switch: taken only when the target runs, then held off by the delay.
    // One switch is in flight at a time; a rewrite during the delay is taken once
    // busy drops, so the gated clock never sees two source changes back to back.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            // Reset selects the primary, which is taken to be running
            cur_src_r <= `PMCS_SRC_PRI;
            pend_src_r <= `PMCS_SRC_PRI;
            dly_r <= {DLY_W{1'b0}};
            busy_r <= 1'b0;
        end else if (busy_r) begin
            // Count down; the new source takes over on the edge busy falls
            if (dly_r == {DLY_W{1'b0}}) begin
                cur_src_r <= pend_src_r;
                busy_r <= 1'b0;
            end else begin
                dly_r <= dly_r - 1'b1;
            end
        end else if (req_src != cur_src_r && (req_onehot & src_running_i) != 3'h0) begin
            // A source not yet running leaves the old one in place until it starts
            pend_src_r <= req_src;
            dly_r <= DLY_LOAD;
            busy_r <= 1'b1;
        end
    end

    // Mode state; halt samples idle select in the same cycle it executes.
    // A register write in that same cycle lands too late for this halt: the
    // core has already committed to the old idle select when it halts.
    always @* begin
        // Hold the state unless one of the events below moves it
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                // Only the halt pulse leaves run; nothing else stops the CPU
                if (halt_i) begin
                    if (osc_r[`PMCS_IDLE_BIT]) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_SLEEP;
                    end
                end
            end
            ST_IDLE, ST_SLEEP: begin
                // A further halt is ignored here, as the core is not executing
                // Wake returns to run on whichever source is current then
                if (wake_i) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                // Unused code falls back to run so the core is never locked out
                state_nxt = ST_RUN;
            end
        endcase
    end

    // State register; reset puts the core in full-power run on the primary
    // Idle and sleep hold here until wake, whatever the register says
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Clock gating and mode report, registered so the gates never glitch.
    // Gates, src_active_o and mode_o follow state_nxt, so they change at the very edge that
    // takes the halt or the wake; src_active_o and mode_o also move when the source switches.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            // Out of reset the core runs at full power on the primary source
            cpu_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            src_active_o <= 3'h1;
            int_fast_en_o <= 1'b0;
            int_slow_en_o <= 1'b0;
            primary_osc_config_o <= 4'h0;
            mode_o <= `PMCS_MODE_PRIMARY_RUN_MODE;
        end else begin
            // Configuration copy is registered with the rest to keep outputs aligned
            primary_osc_config_o <= primary_osc_config_i;
            case (state_nxt)
                ST_RUN: begin
                    // Core and peripherals both run from the current source
                    cpu_clk_en_o <= 1'b1;
                    periph_clk_en_o <= 1'b1;
                    src_active_o <= cur_onehot;
                    mode_o <= MODE_RUN_BASE + src_ofs;
                end
                ST_IDLE: begin
                    // Core stopped, peripherals keep the current source
                    cpu_clk_en_o <= 1'b0;
                    periph_clk_en_o <= 1'b1;
                    src_active_o <= cur_onehot;
                    mode_o <= MODE_IDLE_BASE + src_ofs;
                end
                default: begin
                    // Sleep: every gate shut and no source reported as driving
                    cpu_clk_en_o <= 1'b0;
                    periph_clk_en_o <= 1'b0;
                    src_active_o <= 3'h0;
                    mode_o <= `PMCS_MODE_SLEEP;
                end
            endcase
            // Internal block: fast oscillator with postscaler, or slow RC
            int_fast_en_o <= int_src_on && !int_postscale_sel_i;
            int_slow_en_o <= int_src_on && int_postscale_sel_i;
        end
    end
endmodule

// File: tb/pmcs_assertions.sv
// Checker for the power mode block.
// Assumes one clock and a synchronous reset.
`timescale 1ns/10ps
module pmcs_assertions (
    input wire core_clk_i,
    input wire reset_i,
    input wire osc_wr_i,
    input wire halt_i,
    input wire wake_i,
    input wire [7:0] osc_wdata_i,
    input wire [2:0] src_running_i,
    input wire [7:0] oscillator_control_reg_o,
    input wire cpu_idle_select_o,
    input wire [1:0] clock_source_select_o,
    input wire [2:0] src_active_o,
    input wire cpu_clk_en_o,
    input wire periph_clk_en_o,
    input wire [2:0] mode_o,
    input wire switch_busy_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // Run state with busy low; mode_o still moves on the edge after busy falls
    wire run = cpu_clk_en_o && !switch_busy_o;
    wire [7:0] wexp = osc_wdata_i & 8'h83;
    sequence s_busy4;
        switch_busy_o [*4] ##1 !switch_busy_o;
    endsequence
    property p_wr; osc_wr_i |=> oscillator_control_reg_o == $past(wexp); endproperty
    a_wr: assert property (p_wr) else $error("bad readback");
    property p_dly; $rose(switch_busy_o) |-> s_busy4; endproperty
    a_dly: assert property (p_dly) else $error("bad switch delay");
    property p_go; osc_wr_i && osc_wdata_i[1:0] == 2'h1 && src_active_o == 3'h1 && run
        && src_running_i[1] && !$past(switch_busy_o) |-> ##2 switch_busy_o; endproperty
    a_go: assert property (p_go) else $error("switch not started");
    property p_act; $fell(switch_busy_o) |=> !periph_clk_en_o || src_active_o ==
        (clock_source_select_o[1] ? 3'h4 : clock_source_select_o[0] ? 3'h2 : 3'h1); endproperty
    a_act: assert property (p_act) else $error("wrong source");
    property p_slp; halt_i && run && !cpu_idle_select_o |=> mode_o == 3'h0
        && !periph_clk_en_o && !cpu_clk_en_o && src_active_o == 3'h0; endproperty
    a_slp: assert property (p_slp) else $error("bad sleep");
    property p_idl; halt_i && run && cpu_idle_select_o && !$past(switch_busy_o)
        && !$past(switch_busy_o, 2) |=> !cpu_clk_en_o && periph_clk_en_o
        && mode_o == $past(mode_o) + 3'h3; endproperty
    a_idl: assert property (p_idl) else $error("bad idle");
    property p_hold; cpu_clk_en_o && !halt_i |=> cpu_clk_en_o; endproperty
    a_hold: assert property (p_hold) else $error("left run");
    property p_wake; !cpu_clk_en_o && wake_i |=> cpu_clk_en_o && periph_clk_en_o; endproperty
    a_wake: assert property (p_wake) else $error("no resume");
endmodule

// File: tb/pmcs_core_model.sv
// Core model: turns bench requests into register writes and halts.
// Assumes requests are set just after a clock edge.
`timescale 1ns/10ps
module pmcs_core_model (
    input wire core_clk_i,
    input wire wr_req_i,
    input wire halt_req_i,
    input wire [7:0] data_i,
    output reg osc_wr_o,
    output reg [7:0] osc_wdata_o,
    output reg halt_o
);
    // Idle data lines flip so a stale value is never read as fresh
    always @(posedge core_clk_i) begin
        osc_wr_o <= wr_req_i;
        osc_wdata_o <= wr_req_i ? data_i : ~osc_wdata_o;
        halt_o <= halt_req_i;
    end
endmodule

// File: tb/pmcs_power_mode_clock_select_test.sv
// Bench for the power mode block, driven through the core model.
// Assumes the checker is bound below.
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module pmcs_power_mode_clock_select_test;
    reg core_clk_i = 0, reset_i = 1, wr_q = 0, halt_q = 0, wake_i = 0;
    reg [7:0] data_q = 8'h00;
    reg [2:0] run_q = 3'h7;
    reg [3:0] cfg_q = 4'ha;
    reg post_q = 0;
    wire osc_wr, halt, cpu, per, fast, slow;
    wire [7:0] wdata, rd;
    wire [2:0] act, mode;
    wire [3:0] cfg;
    int err_total = 0, checked = 0;
    always #5 core_clk_i = ~core_clk_i;
    pmcs_core_model core (.core_clk_i(core_clk_i), .wr_req_i(wr_q), .halt_req_i(halt_q),
        .data_i(data_q), .osc_wr_o(osc_wr), .osc_wdata_o(wdata), .halt_o(halt));
    pmcs_power_mode_clock_select dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .osc_wr_i(osc_wr), .osc_wdata_i(wdata), .halt_i(halt), .wake_i(wake_i),
        .primary_osc_config_i(cfg_q), .src_running_i(run_q), .int_postscale_sel_i(post_q),
        .oscillator_control_reg_o(rd), .cpu_idle_select_o(), .clock_source_select_o(),
        .src_active_o(act), .int_fast_en_o(fast), .int_slow_en_o(slow),
        .primary_osc_config_o(cfg),
        .cpu_clk_en_o(cpu), .periph_clk_en_o(per), .mode_o(mode), .switch_busy_o());
    task step(input int n); repeat (n) @(posedge core_clk_i); #1; endtask
    // One request cycle into the core model
    task req(input logic w, input logic h, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_q <= w; halt_q <= h; data_q <= d;
        @(posedge core_clk_i);
        wr_q <= 0; halt_q <= 0;
    endtask
    task wake; @(posedge core_clk_i); wake_i <= 1; @(posedge core_clk_i); wake_i <= 0; #1; endtask
    task t_reset;
        `CHK("run", {rd, cpu, per, act, mode}, {8'h00, 2'b11, 3'h1, 3'h1})
        `CHK("cfg", 4'ha, cfg)
        @(posedge core_clk_i);
        cfg_q <= 4'h5;
        step(1);
        `CHK("cfg new", 4'h5, cfg)
        req(1, 0, 8'h7c); step(1);
        `CHK("reg", 8'h00, rd)
    endtask
    // Target not running holds the switch off
    task t_src;
        req(1, 0, 8'h01);
        step(8);
        `CHK("sec", {act, mode}, 6'h12)
        @(posedge core_clk_i);
        run_q <= 3'h3;
        req(1, 0, 8'h82);
        step(8);
        `CHK("held", 3'h2, act)
        @(posedge core_clk_i);
        run_q <= 3'h7;
        step(9);
        `CHK("int", {rd, act, mode}, 14'h20a3)
        `CHK("fast", {fast, slow}, 2'b10)
        @(posedge core_clk_i);
        post_q <= 1'b1;
        step(1);
        `CHK("slow", {fast, slow}, 2'b01)
        req(1, 0, 8'h80);
        step(8);
        `CHK("pri", {act, mode, fast, slow}, 8'h24)
    endtask
    task t_halt;
        req(0, 1, 8'h00); step(1);
        `CHK("idle", {cpu, per, mode}, 5'h0c)
        req(0, 1, 8'h00); step(1);
        `CHK("ignored", 3'h4, mode)
        wake;
        `CHK("wake", {cpu, mode}, 4'h9)
        req(1, 1, 8'h00); step(1);
        `CHK("same", 3'h4, mode)
        wake;
        req(0, 1, 8'h00); step(1);
        `CHK("sleep", {cpu, per, act, mode}, 8'h00)
        wake;
        `CHK("resume", {act, mode}, 6'h09)
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Guard against a hang
    initial begin #50000; err_total++; report_and_stop; end
    initial begin
        repeat (4) @(posedge core_clk_i);
        reset_i <= 0;
        step(1);
        t_reset; t_src; t_halt;
        report_and_stop;
    end
endmodule
bind pmcs_power_mode_clock_select pmcs_assertions chk (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .osc_wr_i(osc_wr_i),
    .halt_i(halt_i), .wake_i(wake_i), .osc_wdata_i(osc_wdata_i),
    .src_running_i(src_running_i), .oscillator_control_reg_o(oscillator_control_reg_o),
    .cpu_idle_select_o(cpu_idle_select_o), .clock_source_select_o(clock_source_select_o),
    .src_active_o(src_active_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .mode_o(mode_o), .switch_busy_o(switch_busy_o));
